//--- inc/dle_pkg.sv
// Constants, types and helpers shared by the load-class execute block
package dle_pkg;

    // Instruction patterns and the masks that select their fixed bits
    localparam logic [15:0] OPC_SHIFTED = 16'h2000;
    localparam logic [15:0] OPC_BYTE = 16'h7E00;
    localparam logic [15:0] OPC_IDX_MEM = 16'h3800;
    localparam logic [15:0] OPC_IDX_IMM = 16'h7000;
    localparam logic [15:0] OPC_SEL_IDX = 16'h6880;
    localparam logic [15:0] OPC_PAGE_MEM = 16'h6F00;
    localparam logic [15:0] OPC_PAGE_IMM = 16'h6E00;
    localparam logic [15:0] OPC_RESTORE = 16'h7B00;
    localparam logic [15:0] OPC_MUL = 16'h6A00;
    localparam logic [15:0] MASK_NIB = 16'hF000;
    localparam logic [15:0] MASK_BYTE = 16'hFF00;
    localparam logic [15:0] MASK_REG = 16'hFE00;
    localparam logic [15:0] MASK_BIT = 16'hFFFE;

    // Instruction field positions
    localparam int IND_BIT = 7;
    localparam int REG_BIT = 8;
    localparam int SHIFT_LSB = 8;
    localparam int MOD_INC_BIT = 5;
    localparam int MOD_DEC_BIT = 4;
    localparam int MOD_KEEP_BIT = 3;
    localparam int MOD_NEXT_BIT = 0;

    // Saved status word layout
    localparam int ST_OV_BIT = 15;
    localparam int ST_OVM_BIT = 14;
    localparam int ST_IRQ_MASK_BIT_BIT = 13;
    localparam int ST_PTR_BIT = 8;
    localparam int ST_PAGE_BIT = 0;
    localparam logic [15:0] ST_FILL = 16'h1EFE;

    // Reset values
    localparam logic [31:0] RST_SUM = 32'h0000_0000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic RST_BIT = 1'b0;
    localparam logic RST_IRQ_MASK_BIT = 1'b1;

    typedef enum logic [3:0] {
        OP_NONE, OP_SHIFTED, OP_BYTE, OP_IDX_MEM, OP_IDX_IMM,
        OP_SEL_IDX, OP_PAGE_MEM, OP_PAGE_IMM, OP_RESTORE, OP_MUL
    } dle_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} dle_state_t;

    // Word shifted left with zero fill below and sign copies above
    function automatic logic [31:0] dle_shifted(input logic [15:0] w, input logic [3:0] sh);
        logic [31:0] ext;
        ext = {{16{w[15]}}, w};
        return ext << sh;
    endfunction

    // Status word as the save operation lays it out
    function automatic logic [15:0] dle_status(input logic ov, input logic saturate_mode,
                                               input logic irq_mask_bit, input logic ptr,
                                               input logic page);
        logic [15:0] s;
        s = ST_FILL;
        s[ST_OV_BIT] = ov;
        s[ST_OVM_BIT] = saturate_mode;
        s[ST_IRQ_MASK_BIT_BIT] = irq_mask_bit;
        s[ST_PTR_BIT] = ptr;
        s[ST_PAGE_BIT] = page;
        return s;
    endfunction

endpackage

//--- inc/dle_dec_if.sv
// Decoded instruction fields passed from decoder to execute logic
`timescale 1ns/100ps
interface dle_dec_if;
    import dle_pkg::*;
    dle_op_t op;
    logic mem_op;
    logic indirect;
    logic [6:0] addr7;
    logic [3:0] shift;
    logic [7:0] imm8;
    logic reg_sel;
    logic post_inc;
    logic post_dec;
    logic load_ptr;
    logic next_ptr;
    modport drv (output op, mem_op, indirect, addr7, shift, imm8, reg_sel,
                 post_inc, post_dec, load_ptr, next_ptr);
    modport rcv (input op, mem_op, indirect, addr7, shift, imm8, reg_sel,
                 post_inc, post_dec, load_ptr, next_ptr);
endinterface

//--- hw/dle_decode.sv
// Load-class instruction decoder
`timescale 1ns/100ps
module dle_decode import dle_pkg::*; (
    // Instruction word
    input wire logic [15:0] instr,
    // Decoded fields
    dle_dec_if.drv dec
);

    // Pattern test under a mask
    function automatic logic hit(input logic [15:0] w, input logic [15:0] v,
                                 input logic [15:0] m);
        return (w & m) == v;
    endfunction

    // Opcode class matches
    wire logic is_shifted = hit(instr, OPC_SHIFTED, MASK_NIB);
    wire logic is_byte = hit(instr, OPC_BYTE, MASK_BYTE);
    wire logic is_idx_mem = hit(instr, OPC_IDX_MEM, MASK_REG);
    wire logic is_idx_imm = hit(instr, OPC_IDX_IMM, MASK_REG);
    wire logic is_sel_idx = hit(instr, OPC_SEL_IDX, MASK_BIT);
    wire logic is_page_mem = hit(instr, OPC_PAGE_MEM, MASK_BYTE);
    wire logic is_page_imm = hit(instr, OPC_PAGE_IMM, MASK_BIT);
    wire logic is_restore = hit(instr, OPC_RESTORE, MASK_BYTE);
    wire logic is_mul = hit(instr, OPC_MUL, MASK_BYTE);

    // Operation select; patterns are disjoint so order is immaterial
    assign dec.op = is_shifted ? OP_SHIFTED :
                    is_byte ? OP_BYTE :
                    is_idx_mem ? OP_IDX_MEM :
                    is_idx_imm ? OP_IDX_IMM :
                    is_sel_idx ? OP_SEL_IDX :
                    is_page_mem ? OP_PAGE_MEM :
                    is_page_imm ? OP_PAGE_IMM :
                    is_restore ? OP_RESTORE :
                    is_mul ? OP_MUL : OP_NONE;
    assign dec.mem_op = is_shifted | is_idx_mem | is_page_mem | is_restore | is_mul;

    // Operand fields
    assign dec.indirect = instr[IND_BIT];
    assign dec.addr7 = instr[6:0];
    assign dec.shift = instr[SHIFT_LSB +: 4];
    assign dec.imm8 = instr[7:0];
    assign dec.reg_sel = instr[REG_BIT];

    // Indirect modifier: post-modify and optional next pointer
    assign dec.post_inc = instr[IND_BIT] & instr[MOD_INC_BIT];
    assign dec.post_dec = instr[IND_BIT] & instr[MOD_DEC_BIT];
    assign dec.load_ptr = instr[IND_BIT] & ~instr[MOD_KEEP_BIT];
    assign dec.next_ptr = instr[MOD_NEXT_BIT];

endmodule

//--- hw/dle_exec.sv
// Execute logic for accumulator, index, page, status and operand loads
`timescale 1ns/100ps
module dle_exec import dle_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Instruction stream
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    output logic BUSY,
    // Data memory read port
    output logic [7:0] DMEM_ADDR,
    output logic DMEM_RD,
    input wire logic [15:0] DMEM_DATA,
    // Architectural state
    output logic [31:0] SUM_REG,
    output logic [15:0] INDEX_REG0,
    output logic [15:0] INDEX_REG1,
    output logic [15:0] MUL_OPERAND,
    output logic [15:0] STATUS_WORD
);

    dle_dec_if dec_bus ();

    dle_decode u_dec (
        .instr(INSTR),
        .dec(dec_bus)
    );

    dle_state_t state_q, state_d;
    dle_op_t op_q;
    logic [3:0] shift_q;
    logic sel_q, ldptr_q, nxt_q;
    logic [15:0] idx_q [2];
    logic [15:0] idx_d [2];
    logic ptr_q, ptr_d, page_q, page_d;
    logic ov_q, ov_d, ovm_q, ovm_d, irq_mask_bit_q;
    logic [31:0] sum_q, sum_d;
    logic [15:0] mul_q, status_q;
    logic [7:0] addr_q;
    logic rd_q, busy_q;

    // Handshake: a new instruction is only taken while idle
    wire logic take = INSTR_VALID && (state_q == ST_IDLE) && (dec_bus.op != OP_NONE);
    wire logic take_mem = take && dec_bus.mem_op;
    wire logic exec = (state_q == ST_EXEC);
    wire logic [15:0] cur_idx = idx_q[ptr_q];

    // Direct address is page bit over offset; page 1 spans 128 words,
    // so offsets 0 to 127 there map onto addresses 128 to 255 of the read port
    wire logic [7:0] eff_addr = dec_bus.indirect ? cur_idx[7:0]
                                                 : {page_q, dec_bus.addr7};

    // Sequencer: idle, one read cycle, one cycle with data present
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (take_mem) state_d = ST_READ;
            ST_READ: state_d = ST_EXEC;
            ST_EXEC: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Index registers: post-modify at issue, a memory load later overwrites
    always_comb begin
        idx_d = idx_q;
        if (take_mem && dec_bus.post_inc) begin
            idx_d[ptr_q] = cur_idx + 16'h0001;
        end else if (take_mem && dec_bus.post_dec) begin
            idx_d[ptr_q] = cur_idx - 16'h0001;
        end
        if (take && dec_bus.op == OP_IDX_IMM) begin
            idx_d[dec_bus.reg_sel] = {8'h00, dec_bus.imm8};
        end
        if (exec && op_q == OP_IDX_MEM) begin
            idx_d[sel_q] = DMEM_DATA;
        end
    end

    // Pointer, page and status bits; next pointer applies after restore
    always_comb begin
        ptr_d = ptr_q;
        page_d = page_q;
        ov_d = ov_q;
        ovm_d = ovm_q;
        if (take && dec_bus.op == OP_SEL_IDX) ptr_d = dec_bus.next_ptr;
        if (take && dec_bus.op == OP_PAGE_IMM) page_d = dec_bus.next_ptr;
        if (exec && op_q == OP_PAGE_MEM) page_d = DMEM_DATA[0];
        if (exec && op_q == OP_RESTORE) begin
            ov_d = DMEM_DATA[ST_OV_BIT];
            ovm_d = DMEM_DATA[ST_OVM_BIT];
            ptr_d = DMEM_DATA[ST_PTR_BIT];
            page_d = DMEM_DATA[ST_PAGE_BIT];
        end
        if (exec && ldptr_q) ptr_d = nxt_q;
    end

    // Accumulator sources
    assign sum_d = (take && dec_bus.op == OP_BYTE) ? {24'h00_0000, dec_bus.imm8} :
                   (exec && op_q == OP_SHIFTED) ? dle_shifted(DMEM_DATA, shift_q) :
                   sum_q;

    // State and pending-operation latch
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            shift_q <= 4'h0;
            sel_q <= RST_BIT;
            ldptr_q <= RST_BIT;
            nxt_q <= RST_BIT;
        end else begin
            state_q <= state_d;
            if (take_mem) begin
                op_q <= dec_bus.op;
                shift_q <= dec_bus.shift;
                sel_q <= dec_bus.reg_sel;
                ldptr_q <= dec_bus.load_ptr;
                nxt_q <= dec_bus.next_ptr;
            end
        end
    end

    // Architectural registers; the interrupt mask is written only by reset here
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            idx_q[0] <= RST_WORD;
            idx_q[1] <= RST_WORD;
            ptr_q <= RST_BIT;
            page_q <= RST_BIT;
            ov_q <= RST_BIT;
            ovm_q <= RST_BIT;
            irq_mask_bit_q <= RST_IRQ_MASK_BIT;
            sum_q <= RST_SUM;
        end else begin
            idx_q <= idx_d;
            ptr_q <= ptr_d;
            page_q <= page_d;
            ov_q <= ov_d;
            ovm_q <= ovm_d;
            sum_q <= sum_d;
        end
    end

    // Operand register, composed status word and memory port
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mul_q <= RST_WORD;
            status_q <= dle_status(RST_BIT, RST_BIT, RST_IRQ_MASK_BIT, RST_BIT, RST_BIT);
            addr_q <= RST_ADDR;
            rd_q <= RST_BIT;
            busy_q <= RST_BIT;
        end else begin
            if (exec && op_q == OP_MUL) mul_q <= DMEM_DATA;
            status_q <= dle_status(ov_d, ovm_d, irq_mask_bit_q, ptr_d, page_d);
            if (take_mem) addr_q <= eff_addr;
            rd_q <= take_mem;
            busy_q <= (state_d != ST_IDLE);
        end
    end

    assign SUM_REG = sum_q;
    assign INDEX_REG0 = idx_q[0];
    assign INDEX_REG1 = idx_q[1];
    assign MUL_OPERAND = mul_q;
    assign STATUS_WORD = status_q;
    assign DMEM_ADDR = addr_q;
    assign DMEM_RD = rd_q;
    assign BUSY = busy_q;

    // Checks kept beside the logic they guard
    shifted_load_a: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_q == OP_SHIFTED |=> sum_q == dle_shifted($past(DMEM_DATA), $past(shift_q)))
        else $error("shifted load result wrong");
    byte_load_a: assert property (@(posedge CLK) disable iff (!NRST)
        take && INSTR[15:8] == 8'h7E |=> sum_q == {24'h00_0000, $past(INSTR[7:0])} && !busy_q)
        else $error("byte load result wrong");
    idx_mem_a: assert property (@(posedge CLK) disable iff (!NRST)
        take_mem && dec_bus.op == OP_IDX_MEM
        |=> ##2 idx_q[$past(sel_q)] == $past(DMEM_DATA))
        else $error("index memory load lost");
    idx_imm_a: assert property (@(posedge CLK) disable iff (!NRST)
        take && dec_bus.op == OP_IDX_IMM && !dec_bus.reg_sel
        |=> idx_q[0] == {8'h00, $past(INSTR[7:0])})
        else $error("index immediate load wrong");
    sel_ptr_a: assert property (@(posedge CLK) disable iff (!NRST)
        take && dec_bus.op == OP_SEL_IDX |=> ptr_q == $past(INSTR[0]) && status_q[ST_PTR_BIT] == ptr_q)
        else $error("pointer select wrong");
    page_mem_a: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_q == OP_PAGE_MEM |=> page_q == $past(DMEM_DATA[0]))
        else $error("page memory load wrong");
    page_imm_a: assert property (@(posedge CLK) disable iff (!NRST)
        take && dec_bus.op == OP_PAGE_IMM |=> page_q == $past(INSTR[0]))
        else $error("page immediate load wrong");
    restore_mask_a: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_q == OP_RESTORE
        |=> ov_q == $past(DMEM_DATA[ST_OV_BIT]) && ovm_q == $past(DMEM_DATA[ST_OVM_BIT])
            && page_q == $past(DMEM_DATA[ST_PAGE_BIT]) && $stable(status_q[ST_IRQ_MASK_BIT_BIT]))
        else $error("status restore wrong");
    status_fill_a: assert property (@(posedge CLK) disable iff (!NRST)
        (status_q & ST_FILL) == ST_FILL && status_q[ST_PAGE_BIT] == page_q)
        else $error("status word layout wrong");
    mul_load_a: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_q == OP_MUL |=> mul_q == $past(DMEM_DATA))
        else $error("operand load wrong");
    direct_addr_a: assert property (@(posedge CLK) disable iff (!NRST)
        take_mem && !dec_bus.indirect
        |=> DMEM_RD && DMEM_ADDR == {$past(page_q), $past(INSTR[6:0])} ##1 !DMEM_RD ##1 !BUSY)
        else $error("direct read sequence wrong");
    post_inc_a: assert property (@(posedge CLK) disable iff (!NRST)
        take_mem && dec_bus.post_inc |=> idx_q[$past(ptr_q)] == $past(cur_idx) + 16'h0001)
        else $error("index post-increment wrong");
    post_dec_a: assert property (@(posedge CLK) disable iff (!NRST)
        take_mem && dec_bus.post_dec && !dec_bus.post_inc
        |=> idx_q[$past(ptr_q)] == $past(cur_idx) - 16'h0001)
        else $error("index post-decrement wrong");
    // Next pointer lands in the execute cycle, after any restored pointer bit
    next_ptr_a: assert property (@(posedge CLK) disable iff (!NRST)
        exec && ldptr_q |=> ptr_q == $past(nxt_q) && status_q[ST_PTR_BIT] == ptr_q)
        else $error("next pointer not applied");

endmodule

//--- tb/dle_mem_model.sv
// Synchronous data memory model answering the execute block's read port
`timescale 1ns/100ps
module dle_mem_model (
    // Clock
    input wire logic clk,
    // Read request
    input wire logic [7:0] rd_addr,
    input wire logic rd_en,
    // Read data
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:255];

    // Known start pattern so no read returns an unknown by accident
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~16'(i);
        end
        rd_data = 16'h5A5A;
    end

    // Data valid one cycle after the request; toggled otherwise so stale data never matches
    always @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule

//--- tb/dle_exec_tb.sv
// Self-checking testbench for the load-class execute block
`timescale 1ns/100ps
module dle_exec_tb;
    import dle_pkg::*;
    logic CLK;
    logic NRST;
    logic [15:0] INSTR;
    logic INSTR_VALID;
    logic BUSY;
    logic [7:0] DMEM_ADDR;
    logic DMEM_RD;
    logic [15:0] DMEM_DATA;
    logic [31:0] SUM_REG;
    logic [15:0] INDEX_REG0;
    logic [15:0] INDEX_REG1;
    logic [15:0] MUL_OPERAND;
    logic [15:0] STATUS_WORD;
    int fails = 0;
    int checks_done = 0;
    logic [31:0] exp_sum;

    dle_exec i_dle_exec (.CLK(CLK), .NRST(NRST), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
        .BUSY(BUSY), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD), .DMEM_DATA(DMEM_DATA),
        .SUM_REG(SUM_REG), .INDEX_REG0(INDEX_REG0), .INDEX_REG1(INDEX_REG1),
        .MUL_OPERAND(MUL_OPERAND), .STATUS_WORD(STATUS_WORD));

    dle_mem_model i_dle_mem_model (.clk(CLK), .rd_addr(DMEM_ADDR), .rd_en(DMEM_RD),
        .rd_data(DMEM_DATA));

    // Clock at 100 ns period
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Offer one instruction; memory loads also check the read request and wait it out
    task automatic exe(input logic [15:0] ins, input logic memop, input logic [7:0] adr);
        INSTR = ins;
        INSTR_VALID = 1'b1;
        @(posedge CLK);
        #1;
        INSTR_VALID = 1'b0;
        if (memop) begin
            chk("busy_high", BUSY, 32'h1);
            chk("read_req", DMEM_RD, 32'h1);
            chk("read_addr", DMEM_ADDR, adr);
            repeat (2) @(posedge CLK);
            #1;
            chk("busy_low", BUSY, 32'h0);
        end else begin
            // Let an edge pass so the next call never re-raises valid in this step
            @(posedge CLK);
            #1;
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (3000) @(posedge CLK);
        fails++;
        give_verdict();
    end

    initial begin
        NRST = 1'b0;
        INSTR = 16'h0000;
        INSTR_VALID = 1'b0;
        repeat (12) @(posedge CLK);
        #1;
        NRST = 1'b1;
        chk("rst_sum", SUM_REG, 32'h0);
        chk("rst_idx0", INDEX_REG0, 32'h0);
        chk("rst_mul", MUL_OPERAND, 32'h0);
        chk("rst_status", STATUS_WORD, 32'h3EFE);
        // Negative word at every shift amount, page 0 direct
        i_dle_mem_model.mem[10] = 16'h8001;
        for (int sh = 0; sh < 16; sh++) begin
            exe(16'h200A | 16'(sh << 8), 1'b1, 8'h0A);
            exp_sum = {{16{1'b1}}, 16'h8001} << sh;
            chk("shifted", SUM_REG, exp_sum);
        end
        // Byte load must clear the sign-filled upper bits
        exe(16'h7EFF, 1'b0, 8'h00);
        chk("byte_load", SUM_REG, 32'h0000_00FF);
        // Page immediate, then page 1 direct address, then page from bit 0 only
        exe(16'h6E01, 1'b0, 8'h00);
        chk("page_imm", STATUS_WORD[0], 32'h1);
        i_dle_mem_model.mem[8'h83] = 16'hFFFE;
        exe(16'h6F03, 1'b1, 8'h83);
        chk("page_mem", STATUS_WORD[0], 32'h0);
        // Index immediates zero filled
        exe(16'h70C8, 1'b0, 8'h00);
        chk("idx_imm0", INDEX_REG0, 32'h00C8);
        exe(16'h7185, 1'b0, 8'h00);
        chk("idx_imm1", INDEX_REG1, 32'h0085);
        // Select register 1, indirect load with post-increment
        exe(16'h6881, 1'b0, 8'h00);
        chk("sel_ptr", STATUS_WORD[8], 32'h1);
        i_dle_mem_model.mem[8'h85] = 16'h0123;
        exe(16'h20A8, 1'b1, 8'h85);
        chk("ind_sum", SUM_REG, 32'h0000_0123);
        chk("post_inc", INDEX_REG1, 32'h0086);
        // Loading the current register with post-decrement keeps the loaded value
        i_dle_mem_model.mem[8'h86] = 16'h1234;
        exe(16'h3998, 1'b1, 8'h86);
        chk("idx_own", INDEX_REG1, 32'h1234);
        i_dle_mem_model.mem[20] = 16'h5555;
        exe(16'h3814, 1'b1, 8'h14);
        chk("idx_mem0", INDEX_REG0, 32'h5555);
        // Operand load with next pointer 0
        i_dle_mem_model.mem[8'h34] = 16'hBEEF;
        exe(16'h6A80, 1'b1, 8'h34);
        chk("mul_load", MUL_OPERAND, 32'hBEEF);
        chk("next_ptr", STATUS_WORD[8], 32'h0);
        // Offer a byte load while busy: it must be dropped, not queued
        i_dle_mem_model.mem[5] = 16'h0123;
        INSTR = 16'h6A05;
        INSTR_VALID = 1'b1;
        @(posedge CLK);
        #1;
        INSTR = 16'h7E42;
        @(posedge CLK);
        #1;
        INSTR_VALID = 1'b0;
        @(posedge CLK);
        #1;
        // One more idle edge: a queued byte load would have landed by now
        @(posedge CLK);
        #1;
        chk("refused", SUM_REG, 32'h0000_0123);
        chk("mul_direct", MUL_OPERAND, 32'h0123);
        // Restore with mask clear in memory: mask must stay set
        i_dle_mem_model.mem[7] = 16'hDFFF;
        exe(16'h7B07, 1'b1, 8'h07);
        chk("restore_ones", STATUS_WORD, 32'hFFFF);
        i_dle_mem_model.mem[8'h87] = 16'h0000;
        exe(16'h7B07, 1'b1, 8'h87);
        chk("restore_zero", STATUS_WORD, 32'h3EFE);
        give_verdict();
    end
endmodule
